//--- rtl/seeacc_pkg.sv
// Constants and types for the serial EEPROM slave access block.
// Assumes one system clock of 200 MHz and a free-running link sampling clock.
package seeacc_pkg;

   // ------------------------------------------------------------------
   // Array and page geometry
   // ------------------------------------------------------------------
   // Word pointer width: 13 bits for the 8192-byte array, 12 for 4096 bytes
   localparam int MEM_AW = 13;
   localparam int MEM_BYTES = 8192;
   localparam int PAGE_AW = 5;
   localparam int PAGE_BYTES = 32;
   localparam int WADDR_W = 16;

   // ------------------------------------------------------------------
   // Slave address
   // ------------------------------------------------------------------
   // Family identifier; the value is arbitrary
   localparam logic [3:0] FAMILY_ID = 4'h5;

   // ------------------------------------------------------------------
   // Bit slot counts within one byte frame
   // ------------------------------------------------------------------
   localparam logic [3:0] CNT_RESET = 4'h0;
   localparam logic [3:0] CNT_FIRST_TX = 4'h1;
   localparam logic [3:0] CNT_BYTE_DONE = 4'h8;
   localparam logic [3:0] CNT_ACK_SLOT = 4'h9;
   localparam logic [4:0] IDX_LAST = 5'h1F;

   // ------------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------------
   localparam logic [MEM_AW-1:0] PTR_RESET = 13'h0000;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [PAGE_BYTES-1:0] MASK_RESET = 32'h0000_0000;
   localparam logic [31:0] TIMER_RESET = 32'h0000_0000;

   // ------------------------------------------------------------------
   // Programming cycle time
   // ------------------------------------------------------------------
   localparam int WR_TIME_MS = 5;
   localparam int CLK_FREQ_KHZ = 200000;
   localparam int WR_CYCLES = WR_TIME_MS * CLK_FREQ_KHZ;

   // ------------------------------------------------------------------
   // Link state machine
   // ------------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE    = 4'b0000,
      ST_DEVADDR = 4'b0001,
      ST_ADDR_HI = 4'b0010,
      ST_ADDR_LO = 4'b0011,
      ST_WDATA   = 4'b0100,
      ST_RDATA   = 4'b0101,
      ST_WAIT    = 4'b0110,
      ST_PROG    = 4'b0111,
      ST_COMMIT  = 4'b1000
   } seeacc_state_e;

endpackage

//--- rtl/seeacc_top.sv
// Serial EEPROM slave access logic: two-wire slave, page buffer, array, write cycle timer.
// Assumes SCL/SDA/WP/straps are asynchronous pins sampled by a free-running link clock,
// that the outside resolves the open-drain SDA wire from o_sda_oe, and i_resetn on i_clk.
`timescale 1ns/1ps
`default_nettype none

module seeacc_top #(
   parameter int P_WR_CYCLES = seeacc_pkg::WR_CYCLES,        // Programming cycle length in i_clk cycles
   parameter logic [3:0] P_FAMILY_ID = seeacc_pkg::FAMILY_ID // Family identifier, arbitrary value
) (
   input wire logic i_clk,               // System clock, 200 MHz
   input wire logic i_resetn,            // Synchronous reset, active low
   input wire logic i_link_clk,          // Link sampling clock, free running
   input wire logic i_scl,               // Serial clock pin
   input wire logic i_sda,               // Serial data pin level
   output logic o_sda_out,               // Serial data drive value, always low
   output logic o_sda_oe,                // Serial data drive enable, high pulls low
   input wire logic i_wp,                // Write protect pin, high protects
   input wire logic [2:0] i_chip_select_straps, // Slave address strap pins
   output logic o_prog_busy              // Programming cycle running
);

   // ------------------------------------------------------------------
   // Link domain state
   // ------------------------------------------------------------------
   typedef struct packed {
      logic scl_s1;
      logic scl_s2;
      logic scl_d;
      logic sda_s1;
      logic sda_s2;
      logic sda_d;
      logic wp_s1;
      logic wp_s2;
      logic [2:0] strap_s1;
      logic [2:0] strap_s2;
      logic done_s1;
      logic done_s2;
      logic done_d;
      seeacc_pkg::seeacc_state_e state;
      logic [3:0] cnt;
      logic [7:0] shreg;
      logic [7:0] addr_hi;
      logic [seeacc_pkg::MEM_AW-1:0] ptr;
      logic [seeacc_pkg::MEM_AW-seeacc_pkg::PAGE_AW-1:0] page;
      logic [seeacc_pkg::PAGE_BYTES-1:0] mask;
      logic [seeacc_pkg::PAGE_AW-1:0] idx;
      logic mack;
      logic sda_oe;
      logic sda_out;
      logic req_tgl;
   } seeacc_link_s;

   // ------------------------------------------------------------------
   // System domain state
   // ------------------------------------------------------------------
   typedef struct packed {
      logic req_s1;
      logic req_s2;
      logic req_d;
      logic busy;
      logic done_tgl;
      logic [31:0] timer;
   } seeacc_core_s;

   seeacc_link_s link_ff;
   seeacc_link_s nxt_link;
   seeacc_core_s core_ff;
   seeacc_core_s nxt_core;
   logic link_rst_s1_ff;
   logic link_rstn_ff;
   logic [7:0] mem [seeacc_pkg::MEM_BYTES];
   logic [7:0] page_buf [seeacc_pkg::PAGE_BYTES];
   logic [7:0] rd_byte;
   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;
   logic addr_match;
   logic buf_we;
   logic mem_we;
   logic [seeacc_pkg::MEM_AW-1:0] mem_waddr;
   logic [seeacc_pkg::WADDR_W-1:0] word_addr;

   // ------------------------------------------------------------------
   // Link reset synchroniser
   // ------------------------------------------------------------------
   // Brings the system reset onto the link clock; first stage feeds only the second
   always_ff @(posedge i_link_clk) begin
      link_rst_s1_ff <= i_resetn;
      link_rstn_ff <= link_rst_s1_ff;
   end

   // ------------------------------------------------------------------
   // Bus condition decode
   // ------------------------------------------------------------------
   // Edges and start/stop seen on the synchronised pins only
   assign scl_rise = link_ff.scl_s2 & ~link_ff.scl_d;
   assign scl_fall = ~link_ff.scl_s2 & link_ff.scl_d;
   assign bus_start = link_ff.scl_s2 & link_ff.scl_d & link_ff.sda_d & ~link_ff.sda_s2;
   assign bus_stop = link_ff.scl_s2 & link_ff.scl_d & ~link_ff.sda_d & link_ff.sda_s2;
   assign addr_match = (link_ff.shreg[7:4] == P_FAMILY_ID) &&
                       (link_ff.shreg[3:1] == link_ff.strap_s2);
   assign word_addr = {link_ff.addr_hi, link_ff.shreg};
   assign rd_byte = mem[link_ff.ptr];

   // Page buffer takes a byte only when protection is off
   assign buf_we = (link_ff.state == seeacc_pkg::ST_WDATA) && scl_fall &&
                   (link_ff.cnt == seeacc_pkg::CNT_BYTE_DONE) && ~link_ff.wp_s2;

   // Commit walks the page, writing only slots that were received
   assign mem_we = (link_ff.state == seeacc_pkg::ST_COMMIT) && link_ff.mask[link_ff.idx];
   assign mem_waddr = {link_ff.page, link_ff.idx};

   // ------------------------------------------------------------------
   // Link next state
   // ------------------------------------------------------------------
   always_comb begin
      nxt_link = link_ff;
      // Two-stage pin synchronisers and delayed copies
      nxt_link.scl_s1 = i_scl;
      nxt_link.scl_s2 = link_ff.scl_s1;
      nxt_link.scl_d = link_ff.scl_s2;
      nxt_link.sda_s1 = i_sda;
      nxt_link.sda_s2 = link_ff.sda_s1;
      nxt_link.sda_d = link_ff.sda_s2;
      nxt_link.wp_s1 = i_wp;
      nxt_link.wp_s2 = link_ff.wp_s1;
      nxt_link.strap_s1 = i_chip_select_straps;
      nxt_link.strap_s2 = link_ff.strap_s1;
      nxt_link.done_s1 = core_ff.done_tgl;
      nxt_link.done_s2 = link_ff.done_s1;
      nxt_link.done_d = link_ff.done_s2;
      nxt_link.sda_out = 1'b0;

      if (link_ff.state == seeacc_pkg::ST_PROG) begin
         // Bus is ignored until the programming cycle reports done
         nxt_link.sda_oe = 1'b0;
         if (link_ff.done_s2 != link_ff.done_d) begin
            nxt_link.state = seeacc_pkg::ST_COMMIT;
            nxt_link.idx = '0;
         end
      end else if (link_ff.state == seeacc_pkg::ST_COMMIT) begin
         // One page slot per cycle into the array, then answer polling again
         nxt_link.sda_oe = 1'b0;
         nxt_link.idx = link_ff.idx + 1'b1;
         if (link_ff.idx == seeacc_pkg::IDX_LAST) begin
            nxt_link.state = seeacc_pkg::ST_IDLE;
         end
      end else if (bus_stop) begin
         nxt_link.sda_oe = 1'b0;
         nxt_link.cnt = seeacc_pkg::CNT_RESET;
         if ((link_ff.state == seeacc_pkg::ST_WDATA) && (link_ff.mask != seeacc_pkg::MASK_RESET) &&
             ~link_ff.wp_s2) begin
            // Launch the programming cycle in the system domain
            nxt_link.req_tgl = ~link_ff.req_tgl;
            nxt_link.state = seeacc_pkg::ST_PROG;
         end else begin
            nxt_link.state = seeacc_pkg::ST_IDLE;
         end
      end else if (bus_start) begin
         // Start or repeated start: expect a slave address
         nxt_link.sda_oe = 1'b0;
         nxt_link.cnt = seeacc_pkg::CNT_RESET;
         nxt_link.state = seeacc_pkg::ST_DEVADDR;
      end else begin
         unique case (link_ff.state)
            seeacc_pkg::ST_IDLE,
            seeacc_pkg::ST_WAIT: begin
               nxt_link.sda_oe = 1'b0;
            end
            seeacc_pkg::ST_DEVADDR,
            seeacc_pkg::ST_ADDR_HI,
            seeacc_pkg::ST_ADDR_LO,
            seeacc_pkg::ST_WDATA: begin
               if (scl_rise && (link_ff.cnt < seeacc_pkg::CNT_BYTE_DONE)) begin
                  // MSB first shift on each rising clock
                  nxt_link.shreg = {link_ff.shreg[6:0], link_ff.sda_s2};
                  nxt_link.cnt = link_ff.cnt + 1'b1;
               end else if (scl_fall && (link_ff.cnt == seeacc_pkg::CNT_BYTE_DONE)) begin
                  // Byte complete: decide acknowledge for the ninth clock
                  nxt_link.cnt = seeacc_pkg::CNT_ACK_SLOT;
                  unique case (link_ff.state)
                     seeacc_pkg::ST_DEVADDR: begin
                        if (addr_match) begin
                           nxt_link.sda_oe = 1'b1;
                           if (link_ff.shreg[0]) begin
                              nxt_link.state = seeacc_pkg::ST_RDATA;
                              nxt_link.mack = 1'b1;
                           end else begin
                              nxt_link.state = seeacc_pkg::ST_ADDR_HI;
                           end
                        end else begin
                           nxt_link.state = seeacc_pkg::ST_WAIT;
                        end
                     end
                     seeacc_pkg::ST_ADDR_HI: begin
                        // High word address byte first
                        nxt_link.sda_oe = 1'b1;
                        nxt_link.addr_hi = link_ff.shreg;
                        nxt_link.state = seeacc_pkg::ST_ADDR_LO;
                     end
                     seeacc_pkg::ST_ADDR_LO: begin
                        // Pointer set from both bytes, surplus high bits dropped
                        nxt_link.sda_oe = 1'b1;
                        nxt_link.ptr = word_addr[seeacc_pkg::MEM_AW-1:0];
                        nxt_link.page = word_addr[seeacc_pkg::MEM_AW-1:seeacc_pkg::PAGE_AW];
                        nxt_link.mask = seeacc_pkg::MASK_RESET;
                        nxt_link.state = seeacc_pkg::ST_WDATA;
                     end
                     default: begin
                        // Data byte: stored and acknowledged unless protected
                        if (~link_ff.wp_s2) begin
                           nxt_link.sda_oe = 1'b1;
                           nxt_link.mask[link_ff.ptr[seeacc_pkg::PAGE_AW-1:0]] = 1'b1;
                           // Low bits wrap inside the page
                           nxt_link.ptr[seeacc_pkg::PAGE_AW-1:0] =
                              link_ff.ptr[seeacc_pkg::PAGE_AW-1:0] + 1'b1;
                        end else begin
                           nxt_link.sda_oe = 1'b0;
                        end
                     end
                  endcase
               end else if (scl_fall && (link_ff.cnt == seeacc_pkg::CNT_ACK_SLOT)) begin
                  // End of ninth clock: release and await next byte
                  nxt_link.sda_oe = 1'b0;
                  nxt_link.cnt = seeacc_pkg::CNT_RESET;
               end
            end
            seeacc_pkg::ST_RDATA: begin
               if (scl_rise && (link_ff.cnt == seeacc_pkg::CNT_ACK_SLOT)) begin
                  // Sample master acknowledge
                  nxt_link.mack = ~link_ff.sda_s2;
               end else if (scl_fall && (link_ff.cnt == seeacc_pkg::CNT_ACK_SLOT)) begin
                  if (link_ff.mack) begin
                     // Load byte at pointer and drive its MSB
                     nxt_link.shreg = rd_byte;
                     nxt_link.sda_oe = ~rd_byte[7];
                     nxt_link.ptr = link_ff.ptr + 1'b1;
                     nxt_link.cnt = seeacc_pkg::CNT_FIRST_TX;
                  end else begin
                     // No acknowledge: stop driving and wait for stop
                     nxt_link.sda_oe = 1'b0;
                     nxt_link.state = seeacc_pkg::ST_WAIT;
                  end
               end else if (scl_fall && (link_ff.cnt == seeacc_pkg::CNT_BYTE_DONE)) begin
                  // Release the line for the master acknowledge slot
                  nxt_link.sda_oe = 1'b0;
                  nxt_link.cnt = seeacc_pkg::CNT_ACK_SLOT;
               end else if (scl_fall) begin
                  // Next bit, MSB first
                  nxt_link.shreg = {link_ff.shreg[6:0], 1'b0};
                  nxt_link.sda_oe = ~link_ff.shreg[6];
                  nxt_link.cnt = link_ff.cnt + 1'b1;
               end
            end
            default: begin
               nxt_link.state = seeacc_pkg::ST_IDLE;
               nxt_link.sda_oe = 1'b0;
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Link registers
   // ------------------------------------------------------------------
   always_ff @(posedge i_link_clk) begin
      if (!link_rstn_ff) begin
         link_ff <= '0;
         link_ff.scl_s1 <= 1'b1;
         link_ff.scl_s2 <= 1'b1;
         link_ff.scl_d <= 1'b1;
         link_ff.sda_s1 <= 1'b1;
         link_ff.sda_s2 <= 1'b1;
         link_ff.sda_d <= 1'b1;
         link_ff.state <= seeacc_pkg::ST_IDLE;
         link_ff.cnt <= seeacc_pkg::CNT_RESET;
         link_ff.shreg <= seeacc_pkg::BYTE_RESET;
         link_ff.addr_hi <= seeacc_pkg::BYTE_RESET;
         link_ff.ptr <= seeacc_pkg::PTR_RESET;
         link_ff.mask <= seeacc_pkg::MASK_RESET;
      end else begin
         link_ff <= nxt_link;
      end
   end

   // ------------------------------------------------------------------
   // Page buffer and array storage
   // ------------------------------------------------------------------
   // Array changes only during commit after the programming cycle
   always_ff @(posedge i_link_clk) begin
      if (buf_we) begin
         page_buf[link_ff.ptr[seeacc_pkg::PAGE_AW-1:0]] <= link_ff.shreg;
      end
      if (mem_we) begin
         mem[mem_waddr] <= page_buf[link_ff.idx];
      end
   end

   // ------------------------------------------------------------------
   // Programming cycle timer, system domain
   // ------------------------------------------------------------------
   always_comb begin
      nxt_core = core_ff;
      nxt_core.req_s1 = link_ff.req_tgl;
      nxt_core.req_s2 = core_ff.req_s1;
      nxt_core.req_d = core_ff.req_s2;
      if (core_ff.busy) begin
         nxt_core.timer = core_ff.timer + 32'h0000_0001;
         if (core_ff.timer == 32'(P_WR_CYCLES - 1)) begin
            // Cycle over: report done to the link side
            nxt_core.busy = 1'b0;
            nxt_core.done_tgl = ~core_ff.done_tgl;
         end
      end else if (core_ff.req_s2 != core_ff.req_d) begin
         nxt_core.busy = 1'b1;
         nxt_core.timer = seeacc_pkg::TIMER_RESET;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         core_ff <= '0;
      end else begin
         core_ff <= nxt_core;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign o_sda_out = link_ff.sda_out;
   assign o_sda_oe = link_ff.sda_oe;
   assign o_prog_busy = core_ff.busy;

endmodule

`default_nettype wire

//--- tb/seeacc_properties.sv
// Concurrent checks on the ports of the serial EEPROM slave access block.
// Assumes it is bound onto seeacc_top; link checks use the link sampling clock.
`timescale 1ns/1ps
`default_nettype none
module seeacc_properties #(
   parameter int P_WR_CYCLES = 50 // Programming cycle length
) (
   input wire logic i_clk,      // System clock
   input wire logic i_resetn,   // Reset, active low
   input wire logic i_link_clk, // Link sampling clock
   input wire logic i_scl,      // Serial clock pin
   input wire logic i_sda,      // Data wire level
   input wire logic o_sda_out,  // Data drive value
   input wire logic o_sda_oe,   // Data drive enable
   input wire logic i_wp,       // Write protect pin
   input wire logic o_prog_busy // Programming cycle running
);
   logic [31:0] busy_cnt_ff;
   logic [31:0] nxt_busy_cnt;
   // Length of the running programming cycle
   always_comb nxt_busy_cnt = o_prog_busy ? busy_cnt_ff + 32'h0000_0001 : 32'h0000_0000;
   always_ff @(posedge i_clk) busy_cnt_ff <= nxt_busy_cnt;
   logic [3:0] link_up_ff = 4'h0;
   logic link_off;
   // Link side leaves reset some link clocks after the system reset, so hold link checks off until then
   always @(posedge i_link_clk) link_up_ff <= {link_up_ff[2:0], i_resetn};
   assign link_off = !i_resetn || !link_up_ff[3];
   // Stop condition, then a released data line
   sequence stop_s;
      i_scl && $past(i_scl) && $rose(i_sda);
   endsequence
   sequence quiet_s;
      !o_sda_oe [*8];
   endsequence
   sda_out_low_a: assert property (@(posedge i_link_clk) disable iff (link_off) o_sda_out == 1'b0)
      else $error("data drive value not low");
   ack_steady_a: assert property (@(posedge i_link_clk) disable iff (link_off)
      i_scl && $past(i_scl) |-> $stable(o_sda_oe)) else $error("data drive changed while clock high");
   idle_release_a: assert property (@(posedge i_link_clk) disable iff (link_off)
      stop_s |=> quiet_s) else $error("data driven after stop");
   busy_quiet_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      o_prog_busy |-> !o_sda_oe) else $error("acknowledge while programming");
   busy_length_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      $fell(o_prog_busy) |-> busy_cnt_ff == 32'(P_WR_CYCLES)) else $error("programming length wrong");
   busy_gap_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      $fell(o_prog_busy) |=> !o_prog_busy [*8]) else $error("programming restarted at once");
   wp_no_prog_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      i_wp |-> !$rose(o_prog_busy)) else $error("programming while protected");
   busy_reset_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      $rose(i_resetn) |-> !o_prog_busy) else $error("busy after reset");
endmodule
bind seeacc_top seeacc_properties #(.P_WR_CYCLES(P_WR_CYCLES)) i_seeacc_properties (.i_clk(i_clk),
   .i_resetn(i_resetn), .i_link_clk(i_link_clk), .i_scl(i_scl), .i_sda(i_sda), .o_sda_out(o_sda_out),
   .o_sda_oe(o_sda_oe), .i_wp(i_wp), .o_prog_busy(o_prog_busy));
`default_nettype wire

//--- tb/seeacc_mst.sv
// Two-wire bus master model: makes the serial clock, start, stop and data bits.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module seeacc_mst #(
   parameter int P_HALF = 32 // Clock phase in i_clk cycles
) (
   input wire logic i_clk, // Pacing clock
   input wire logic i_sda, // Resolved data wire
   output logic o_scl,     // Serial clock, idle high
   output logic o_sda_oe   // High pulls data low
);
   // Idle bus
   initial begin
      o_scl = 1'b1;
      o_sda_oe = 1'b0;
   end
   task automatic half(input int n);
      repeat (n) @(posedge i_clk);
   endtask
   // Start or repeated start, data falls while clock high
   task automatic start();
      o_sda_oe <= 1'b0;
      half(P_HALF);
      o_scl <= 1'b1;
      half(P_HALF);
      o_sda_oe <= 1'b1;
      half(P_HALF);
      o_scl <= 1'b0;
      half(P_HALF / 2);
   endtask
   // Stop, data rises while clock high
   task automatic stop();
      o_sda_oe <= 1'b1;
      half(P_HALF);
      o_scl <= 1'b1;
      half(P_HALF);
      o_sda_oe <= 1'b0;
      half(P_HALF);
   endtask
   // Eight bits first MSB, then a ninth clock carrying ack_bit; data moves only while clock low
   task automatic xfer(input logic [7:0] d, input logic ack_bit, output logic [7:0] q, output logic ack);
      logic [8:0] s;
      s = {d, ack_bit};
      for (int i = 8; i >= 0; i--) begin
         o_sda_oe <= !s[i];
         half(P_HALF);
         o_scl <= 1'b1;
         half(P_HALF);
         s[i] = i_sda;
         o_scl <= 1'b0;
         half(P_HALF / 2);
      end
      q = s[8:1];
      ack = !s[0];
   endtask
endmodule
`default_nettype wire

//--- tb/tb_seeacc_top.sv
// Self-checking bench for the serial EEPROM slave access block.
// Assumes the master model and the checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tb_seeacc_top;
   logic i_clk = 1'b0;
   logic i_link_clk = 1'b0;
   logic i_resetn = 1'b0;
   logic i_wp = 1'b0;
   logic [2:0] i_chip_select_straps = 3'h0;
   logic scl, m_oe, o_sda_out, o_sda_oe, o_prog_busy;
   logic busy_seen = 1'b0;
   logic [7:0] mem [8192];
   logic [31:0] lfsr = 32'h0001_412B;
   logic [12:0] ptr = 13'h0000;
   int err_count = 0;
   int checks = 0;
   int cyc = 0;
   // Open-drain wire with pull-up; the slave pulls low only with a low drive value
   wire logic sda = ~m_oe & (~o_sda_oe | o_sda_out);
   // System clock and an unrelated link clock
   always #2.5 i_clk = ~i_clk;
   initial #7 forever #24 i_link_clk = ~i_link_clk;
   seeacc_top #(.P_WR_CYCLES(50)) i_seeacc_top (.i_clk(i_clk), .i_resetn(i_resetn), .i_link_clk(i_link_clk),
      .i_scl(scl), .i_sda(sda), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .i_wp(i_wp),
      .i_chip_select_straps(i_chip_select_straps), .o_prog_busy(o_prog_busy));
   seeacc_mst i_seeacc_mst (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(m_oe));
   // Programming monitor and hang limit
   always @(posedge i_clk) begin
      if (o_prog_busy === 1'b1) busy_seen = 1'b1;
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         err_count++;
         tally_and_finish();
      end
   end
   // ---------------------------------------------
   // Expectation and bus helpers
   // ---------------------------------------------
   function automatic logic [31:0] lfsr_step(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [12:0] pg_addr(input logic [12:0] a, input int n);
      return {a[12:5], a[4:0] + 5'(n)};
   endfunction
   function automatic logic [7:0] dev(input logic rw);
      return {seeacc_pkg::FAMILY_ID, i_chip_select_straps, rw};
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic hdr(input logic [7:0] b, output logic ack);
      logic [7:0] q;
      i_seeacc_mst.start();
      i_seeacc_mst.xfer(b, 1'b1, q, ack);
   endtask
   // Poll the slave address until acknowledged
   task automatic poll(input logic prog);
      logic ack;
      for (int k = 0; k < 20; k++) begin
         hdr(dev(1'b0), ack);
         i_seeacc_mst.stop();
         if (k == 0) chk(8'(ack), 8'(!prog));
         if (ack === 1'b1) break;
      end
      chk(8'(ack), 8'h01);
      chk(8'(busy_seen), 8'(prog));
   endtask
   // Write n random bytes from a; with n of zero the bus stays open for a read
   task automatic wr(input logic [15:0] a, input int n);
      logic [7:0] q, d;
      logic ack;
      hdr(dev(1'b0), ack);
      chk(8'(ack), 8'h01);
      i_seeacc_mst.xfer(a[15:8], 1'b1, q, ack);
      chk(8'(ack), 8'h01);
      i_seeacc_mst.xfer(a[7:0], 1'b1, q, ack);
      chk(8'(ack), 8'h01);
      for (int i = 0; i < n; i++) begin
         lfsr = lfsr_step(lfsr);
         d = lfsr[7:0];
         i_seeacc_mst.xfer(d, 1'b1, q, ack);
         chk(8'(ack), 8'(!i_wp));
         if (!i_wp) mem[pg_addr(a[12:0], i)] = d;
      end
      ptr = pg_addr(a[12:0], i_wp ? 0 : n);
      if (n > 0) begin
         busy_seen = 1'b0;
         i_seeacc_mst.stop();
         poll(!i_wp);
      end
   endtask
   // Read n bytes from the pointer, the last one left unacknowledged
   task automatic rd(input int n);
      logic [7:0] q;
      logic ack;
      hdr(dev(1'b1), ack);
      chk(8'(ack), 8'h01);
      for (int i = 0; i < n; i++) begin
         i_seeacc_mst.xfer(8'hFF, i == n - 1, q, ack);
         chk(q, mem[ptr]);
         ptr = ptr + 13'h0001;
      end
      i_seeacc_mst.stop();
   endtask
   task automatic tally_and_finish();
      $display("checks=%0d err_count=%0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // Main sequence
   initial begin
      logic ack;
      repeat (16) @(posedge i_clk);
      i_resetn <= 1'b1;
      i_chip_select_straps <= lfsr[2:0];
      repeat (40) @(posedge i_clk);
      hdr({seeacc_pkg::FAMILY_ID, ~i_chip_select_straps, 1'b0}, ack);
      i_seeacc_mst.stop();
      chk(8'(ack), 8'h00);
      wr(16'hFFFD, 3);
      wr(16'h001E, 34);
      rd(1);
      @(posedge i_clk) i_wp <= 1'b1;
      wr(16'h0005, 2);
      @(posedge i_clk) i_wp <= 1'b0;
      wr(16'h1FFD, 0);
      rd(34);
      rd(1);
      tally_and_finish();
   end
endmodule
`default_nettype wire
